// file: logic/cfo_ctrl.sv
// clock fan-out control top: pin routing, dividers, banks and apb registers
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cfo_defines.svh"

// Contract
// RULE1: reference_select low routes reference pair a to the pll, high pair b.
// RULE2: feedback_select low takes feedback from pair a, high from pair b.
// RULE3: phase_acquired_n is low while the pll is locked and high otherwise.
// RULE4: every bank picks its own divider and driver type independently.
// RULE5: gating by sync_output_gate is enabled per bank, others ignore it.
// RULE6: a gated bank outputs the clock while the gate is high, a level else.
// RULE7: gated banks start and stop only on whole divided-clock cycles.
// RULE8: each output is always on, always off, or follows one of two enables.
// RULE9: global_tristate_ctrl high puts every clock output in high impedance.
// RULE10: global_tristate_ctrl high also kills the feedback buffer and lock.
// RULE11: the two profile select pins choose one of four stored profiles.
// RULE12: with loop_bypass_ctrl low the dividers run from the vco.
// RULE13: with loop_bypass_ctrl high the dividers run from the prescaler.
// RULE14: the reset pin clears all counters and reports loss of lock.
// RULE15: gate and enables are resynchronised to each bank's divided clock.
module cfo_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cfo_pkg::cfo_pins_t pins,
  output logic pll_ref_clk,
  output logic pll_fb_clk,
  output logic fb_buf_en,
  output logic phase_acquired_n,
  output logic [1:0] active_profile,
  output logic [2*`CFO_NUM_BANKS-1:0] bank_out,
  output logic [2*`CFO_NUM_BANKS-1:0] bank_oe_n,
  output logic [3*`CFO_NUM_BANKS-1:0] bank_drv_type
);
  import cfo_pkg::*;

  localparam int NB = `CFO_NUM_BANKS;
  localparam int NV = `CFO_NUM_VDIV;
  // decode bases as sized constants so their upper bits can be sliced
  localparam logic [11:0] VDIV_BASE = `CFO_OFF_VDIV_BASE;
  localparam logic [11:0] PROF_BASE = `CFO_OFF_PROF_BASE;

  // synced pins, divider state and bus registers
  cfo_pins_t sp;
  logic [7:0] vdiv_r [NV];
  cfo_bank_cfg_t cfg_r [`CFO_NUM_PROF][NB];
  logic [7:0] cnt_r [NV];
  logic [NV-1:0] div_lvl_r;
  logic src_prev_r;
  logic src_lvl;
  logic src_tick;
  logic clr;
  logic [1:0] prof;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic ref_r;
  logic fb_r;
  logic fb_en_r;
  logic lock_n_r;
  logic [1:0] prof_r;
  logic [3*NB-1:0] drv_r;
  logic hit;
  logic is_vdiv;
  logic is_prof;
  logic [31:0] rdata;
  logic wr;
  logic [3:0] bank_idx;
  logic [1:0] prof_idx;
  logic [2:0] vdiv_idx;
  logic acc;

  // pins cross into the pclk domain through three sync flops and a filter flop each
  cfo_sync3 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins_in(pins),
    .pins_out(sp)
  );

  // functional reset and profile choice from the synced pins
  assign clr = sp.pll_reset_in;
  assign prof = {sp.profile_sel_bit1, sp.profile_sel_bit0}; // RULE11

  // pll reference steering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_r <= 1'b0;
    end else begin
      ref_r <= sp.reference_select ? sp.ref_input_pair_b
                                   : sp.ref_input_pair_a; // RULE1
    end
  end

  // feedback steering; tristate kills the feedback path as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_r <= 1'b0;
    end else begin
      fb_r <= (sp.feedback_select ? sp.feedback_input_pair_b
                                  : sp.feedback_input_pair_a)
              & ~sp.global_tristate_ctrl; // RULE2 RULE10
    end
  end

  // feedback buffer enable follows the inverted synced tristate pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_en_r <= 1'b0;
    end else begin
      fb_en_r <= ~sp.global_tristate_ctrl; // RULE10
    end
  end

  // lock drops at once with reset or tristate, analog lag not modelled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_n_r <= 1'b1;
    end else begin
      lock_n_r <= ~(sp.pll_lock_det & ~clr
                    & ~sp.global_tristate_ctrl); // RULE3 RULE10 RULE14
    end
  end

  // active profile switches live with the synced select pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prof_r <= 2'h0;
    end else begin
      prof_r <= prof;
    end
  end

  // divider source: vco normally, prescaler when the loop is bypassed
  assign src_lvl = sp.loop_bypass_ctrl ? sp.ref_prescaler_in // RULE13
                                       : sp.vco_clk_in; // RULE12
  assign src_tick = src_lvl & ~src_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_lvl;
    end
  end

  // five dividers; output toggles every ratio source edges (ratio 0 acts as 1)
  genvar v;
  generate
    for (v = 0; v < NV; v++) begin : g_vdiv
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r[v] <= 8'h00;
          div_lvl_r[v] <= 1'b0;
        end else if (clr) begin
          cnt_r[v] <= 8'h00; // RULE14
          div_lvl_r[v] <= 1'b0;
        end else if (src_tick) begin
          if (cnt_r[v] + 8'h01 >= vdiv_r[v]) begin
            cnt_r[v] <= 8'h00;
            div_lvl_r[v] <= ~div_lvl_r[v];
          end else begin
            cnt_r[v] <= cnt_r[v] + 8'h01;
          end
        end
      end
    end
  endgenerate

  // banks take their settings from the active profile
  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_bank
      cfo_bank_cfg_t c;
      logic dl;
      assign c = cfg_r[prof][b];
      // out-of-range selections fall back to the last divider
      assign dl = (c.div_sel < 3'(NV)) ? div_lvl_r[c.div_sel]
                                       : div_lvl_r[NV-1]; // RULE4
      cfo_bank u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .clr(clr),
        .div_lvl(dl),
        .cfg(c),
        .gate(sp.sync_output_gate),
        .en_one(sp.alt_enable_one),
        .en_two(sp.alt_enable_two),
        .tristate(sp.global_tristate_ctrl),
        .out_r(bank_out[2*b +: 2]),
        .oe_n_r(bank_oe_n[2*b +: 2])
      );
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          drv_r[3*b +: 3] <= 3'h0;
        end else begin
          drv_r[3*b +: 3] <= c.drv_type; // RULE4
        end
      end
    end
  endgenerate

  // apb address decode
  assign vdiv_idx = paddr[4:2];
  assign prof_idx = paddr[7:6];
  assign bank_idx = paddr[5:2];
  assign is_vdiv = (paddr[11:5] == VDIV_BASE[11:5])
                   && (vdiv_idx < 3'(NV)) && (paddr[1:0] == 2'h0);
  assign is_prof = (paddr[11:8] == PROF_BASE[11:8])
                   && (bank_idx < 4'(NB)) && (paddr[1:0] == 2'h0);
  assign hit = is_vdiv || is_prof || (paddr == `CFO_OFF_STATUS);

  // read mux; status fields are the live synced pin levels, except lock and profile, taken from their output registers
  always_comb begin
    rdata = 32'h0000_0000;
    if (is_vdiv) begin
      rdata = {24'h00_0000, vdiv_r[vdiv_idx]};
    end else if (is_prof) begin
      rdata = {21'h00_0000, cfg_r[prof_idx][bank_idx]};
    end else if (paddr == `CFO_OFF_STATUS) begin
      rdata[`CFO_ST_LOCKED] = ~lock_n_r;
      rdata[`CFO_ST_PROF_LO +: 2] = prof_r;
      rdata[`CFO_ST_BYPASS] = sp.loop_bypass_ctrl;
      rdata[`CFO_ST_TRISTATE] = sp.global_tristate_ctrl;
      rdata[`CFO_ST_PLL_RST] = clr;
      rdata[`CFO_ST_REF_SEL] = sp.reference_select;
      rdata[`CFO_ST_FB_SEL] = sp.feedback_select;
    end
  end

  // an access cycle still waiting for its answer
  assign acc = psel && penable && !pready_r;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= acc;
    end
  end

  // error rides with pready for any address nothing decodes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= acc && !hit;
    end
  end

  // read data captured with pready and held until the next answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (acc) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rdata;
    end
  end

  // writes land only on the completing edge, never on a refused address
  assign wr = psel && penable && pready_r && pwrite && hit;

  // divider ratio store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NV; i++) begin
        vdiv_r[i] <= `CFO_VDIV_RST;
      end
    end else if (wr && is_vdiv) begin
      vdiv_r[vdiv_idx] <= pwdata[7:0];
    end
  end

  // profile store; status is read-only so writes to it are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < `CFO_NUM_PROF; p++) begin
        for (int k = 0; k < NB; k++) begin
          cfg_r[p][k] <= cfo_bank_cfg_t'(`CFO_BANK_CFG_RST);
        end
      end
    end else if (wr && is_prof) begin
      cfg_r[prof_idx][bank_idx] <= cfo_bank_cfg_t'(pwdata[10:0]);
    end
  end

  // every port straight from its register
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pll_ref_clk = ref_r;
  assign pll_fb_clk = fb_r;
  assign fb_buf_en = fb_en_r;
  assign phase_acquired_n = lock_n_r;
  assign active_profile = prof_r;
  assign bank_drv_type = drv_r;
endmodule // cfo_ctrl
`default_nettype wire

// file: logic/cfo_defines.svh
// register offsets, field positions, reset values for the clock fan-out control
`ifndef CFO_DEFINES_SVH
`define CFO_DEFINES_SVH

`define CFO_NUM_BANKS 10
`define CFO_NUM_VDIV 5
`define CFO_NUM_PROF 4

// divider ratio registers, one word each from this base
`define CFO_OFF_VDIV_BASE 12'h000
`define CFO_OFF_STATUS 12'h020
// profile/bank configuration words: base + profile*0x40 + bank*4
`define CFO_OFF_PROF_BASE 12'h100

`define CFO_VDIV_RST 8'h01
// both outputs always driven, divider 0, no gating
`define CFO_BANK_CFG_RST 11'h280

`define CFO_ST_LOCKED 0
`define CFO_ST_PROF_LO 1
`define CFO_ST_BYPASS 3
`define CFO_ST_TRISTATE 4
`define CFO_ST_PLL_RST 5
`define CFO_ST_REF_SEL 6
`define CFO_ST_FB_SEL 7

`endif

// file: logic/cfo_pkg.sv
// types shared by the clock fan-out control files
package cfo_pkg;

  typedef enum logic [1:0] {
    CFO_OE_OFF = 2'h0,
    CFO_OE_ON = 2'h1,
    CFO_OE_ONE = 2'h2,
    CFO_OE_TWO = 2'h3
  } cfo_oe_mode_t;

  typedef struct packed {
    cfo_oe_mode_t oe_b;
    cfo_oe_mode_t oe_a;
    logic gate_en;
    logic [2:0] drv_type;
    logic [2:0] div_sel;
  } cfo_bank_cfg_t;

  // board pins sampled into the pclk domain
  typedef struct packed {
    logic pll_lock_det;
    logic ref_prescaler_in;
    logic vco_clk_in;
    logic pll_reset_in;
    logic loop_bypass_ctrl;
    logic profile_sel_bit1;
    logic profile_sel_bit0;
    logic global_tristate_ctrl;
    logic alt_enable_two;
    logic alt_enable_one;
    logic sync_output_gate;
    logic feedback_input_pair_b;
    logic feedback_input_pair_a;
    logic ref_input_pair_b;
    logic ref_input_pair_a;
    logic feedback_select;
    logic reference_select;
  } cfo_pins_t;

endpackage

// file: logic/cfo_sync3.sv
// three-flop pin synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cfo_sync3 (
  input wire logic pclk,
  input wire logic presetn,
  input wire cfo_pkg::cfo_pins_t pins_in,
  output cfo_pkg::cfo_pins_t pins_out
);
  import cfo_pkg::*;

  localparam int W = $bits(cfo_pins_t);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second; filter looks at two and three
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          q_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= pins_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            q_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  assign pins_out = cfo_pins_t'(q_r);
endmodule // cfo_sync3
`default_nettype wire

// file: logic/cfo_bank.sv
// one output bank: whole-cycle gating and output enables
`timescale 1ns/1ps
`default_nettype none
module cfo_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic div_lvl,
  input wire cfo_pkg::cfo_bank_cfg_t cfg,
  input wire logic gate,
  input wire logic en_one,
  input wire logic en_two,
  input wire logic tristate,
  output logic [1:0] out_r,
  output logic [1:0] oe_n_r
);
  import cfo_pkg::*;

  logic div_prev_r;
  logic gate_q_r;
  logic [1:0] en_q_r;
  logic div_fall;
  logic [1:0] en_want;

  assign div_fall = div_prev_r & ~div_lvl;

  function automatic logic oe_decode(cfo_oe_mode_t m, logic a, logic b);
    case (m)
      CFO_OE_ON: oe_decode = 1'b1;
      CFO_OE_ONE: oe_decode = a;
      CFO_OE_TWO: oe_decode = b;
      default: oe_decode = 1'b0;
    endcase
  endfunction

  assign en_want = {oe_decode(cfg.oe_b, en_one, en_two),
                    oe_decode(cfg.oe_a, en_one, en_two)};

  // gate and enables are taken only at the divided clock's falling edge,
  // with the output already low, so no pulse is ever cut short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_prev_r <= 1'b0;
      gate_q_r <= 1'b0;
      en_q_r <= 2'h0;
    end else if (clr) begin
      div_prev_r <= 1'b0;
      gate_q_r <= 1'b0;
      en_q_r <= 2'h0;
    end else begin
      div_prev_r <= div_lvl;
      if (div_fall) begin
        gate_q_r <= gate; // RULE7 RULE15
        en_q_r <= en_want; // RULE15
      end
    end
  end

  // clock level; a gated bank parks low while the gate is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= 2'h0;
    end else if (cfg.gate_en) begin // RULE5
      out_r <= {2{div_lvl & gate_q_r}}; // RULE6
    end else begin
      out_r <= {2{div_lvl}};
    end
  end

  // enables low-active; global tristate wins over everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_r <= 2'h3;
    end else if (tristate) begin
      oe_n_r <= 2'h3; // RULE9
    end else begin
      oe_n_r <= ~en_q_r; // RULE8
    end
  end
endmodule // cfo_bank
`default_nettype wire

// file: tb/cfo_ctrl_properties.sv
// port assertions for the clock fan-out control
`timescale 1ns/1ps
`default_nettype none
`include "cfo_defines.svh"
module cfo_ctrl_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire cfo_pkg::cfo_pins_t pins,
  input wire logic pll_ref_clk,
  input wire logic pll_fb_clk,
  input wire logic fb_buf_en,
  input wire logic phase_acquired_n,
  input wire logic [1:0] active_profile,
  input wire logic [2*`CFO_NUM_BANKS-1:0] bank_oe_n
);
  import cfo_pkg::*;
  logic [2:0] rsel;
  logic [2:0] fsel;
  logic tri_p;
  // selector and both pair levels, so one index picks the routed level
  assign rsel = {pins.reference_select, pins.ref_input_pair_b,
    pins.ref_input_pair_a};
  assign fsel = {pins.feedback_select, pins.feedback_input_pair_b,
    pins.feedback_input_pair_a};
  assign tri_p = pins.global_tristate_ctrl;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // seven samples cover the pin synchroniser and the output register
  tri_hiz_a: assert property (tri_p [*7] |-> &bank_oe_n)
    else $error("output driven in tristate");
  fb_off_a: assert property (tri_p [*7] |->
    !fb_buf_en && phase_acquired_n && !pll_fb_clk)
    else $error("feedback alive in tristate");
  lock_on_a: assert property ((pins.pll_lock_det && !tri_p &&
    !pins.pll_reset_in) [*7] |-> !phase_acquired_n)
    else $error("lock not reported");
  lock_off_a: assert property (!pins.pll_lock_det [*7] |->
    phase_acquired_n)
    else $error("lock reported without lock");
  pll_rst_a: assert property (pins.pll_reset_in [*7] |->
    phase_acquired_n && &bank_oe_n)
    else $error("reset pin ignored");
  ref_sel_a: assert property ($stable(rsel) [*7] |->
    pll_ref_clk == rsel[rsel[2]])
    else $error("wrong reference pair");
  fb_sel_a: assert property (($stable(fsel) && !tri_p) [*7] |->
    pll_fb_clk == fsel[fsel[2]])
    else $error("wrong feedback pair");
  prof_sel_a: assert property ($stable({pins.profile_sel_bit1,
    pins.profile_sel_bit0}) [*7] |-> active_profile ==
    {pins.profile_sel_bit1, pins.profile_sel_bit0})
    else $error("wrong active profile");
  bus_wait_a: assert property (psel && !penable |=>
    !pready ##1 pready ##1 !pready)
    else $error("bus answer timing");
  tri_c: cover property (tri_p ##6 &bank_oe_n);
  lock_c: cover property ($fell(phase_acquired_n));
  err_c: cover property (pready && pslverr);
endmodule // cfo_ctrl_properties
`default_nettype wire

// file: tb/cfo_board.sv
// board model: vco and prescaler sources and the pll lock detector
`timescale 1ns/1ps
`default_nettype none
module cfo_board (
  input wire logic pclk,
  input wire logic fb_en,
  output logic vco,
  output logic pre,
  output logic lock
);
  int cnt;
  // free sources, edges kept away from pclk rising edges on purpose
  initial begin
    vco = 1'b0;
    forever #100 vco = ~vco;
  end
  initial begin
    pre = 1'b0;
    forever #250 pre = ~pre;
  end
  // lock needs the feedback buffer on for a while; no jitter modelled
  always @(posedge pclk) begin
    if (fb_en !== 1'b1)
      cnt <= 0;
    else if (cnt < 20)
      cnt <= cnt + 1;
  end
  assign lock = (cnt == 20);
endmodule // cfo_board
`default_nettype wire

// file: tb/cfo_ctrl_tb.sv
// self-checking bench for the clock fan-out control
`timescale 1ns/1ps
`default_nettype none
`include "cfo_defines.svh"
module cfo_ctrl_tb;
  import cfo_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pll_ref_clk, pll_fb_clk, fb_buf_en, phase_acquired_n;
  logic vco, pre, lk;
  logic [1:0] active_profile;
  logic [19:0] bank_out, bank_oe_n;
  logic [29:0] bank_drv_type;
  cfo_pins_t pn, pins;
  int err_total, checked;
  // bench pins with the board sources laid over them
  always_comb begin
    pins = pn;
    pins.vco_clk_in = vco;
    pins.ref_prescaler_in = pre;
    pins.pll_lock_det = lk;
  end
  cfo_board brd_u (.pclk(pclk), .fb_en(fb_buf_en), .vco(vco), .pre(pre),
    .lock(lk));
  cfo_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pins, .pll_ref_clk, .pll_fb_clk,
    .fb_buf_en, .phase_acquired_n, .active_profile, .bank_out, .bank_oe_n,
    .bank_drv_type);
  // 40 mhz bus clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, x);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, x, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one transfer, entered just after an edge; one idle edge follows
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", pready, 1);
    @(posedge pclk);
  endtask
  // pulse widths on one bank output, optionally toggling the gate
  task automatic pulses(input int b, input int w, input bit tog);
    int run, seen;
    logic p;
    run = 0;
    seen = 0;
    p = 1'b1;
    for (int k = 1; k <= 240; k++) begin
      @(posedge pclk);
      if (tog && k % 29 == 0)
        pn.sync_output_gate <= !pn.sync_output_gate;
      if (bank_out[b] && !p)
        run = 1;
      else if (bank_out[b] && run > 0)
        run++;
      else if (!bank_out[b] && p && run > 0) begin
        chk("width", run, w);
        seen++;
      end
      if (!bank_out[b])
        run = 0;
      p = bank_out[b];
    end
    chk("pulses", seen > 0, 1);
  endtask
  task automatic t_regs();
    apb(0, `CFO_OFF_STATUS, 0);
    chk("status", rd, 0);
    apb(0, `CFO_OFF_VDIV_BASE, 0);
    chk("vdiv0", rd, 1);
    apb(0, 12'h14c, 0);
    chk("bankcfg", rd, 32'h280);
    apb(1, 12'h010, 32'h33);
    apb(0, 12'h010, 0);
    chk("vdiv4", rd, 32'h33);
    apb(0, 12'h040, 0);
    chk("hole err", er, 1);
    chk("hole data", rd, 0);
  endtask
  task automatic t_route();
    for (int i = 0; i < 4; i++) begin
      pn.reference_select <= i[0];
      pn.feedback_select <= i[0];
      pn.ref_input_pair_a <= i[1];
      pn.ref_input_pair_b <= !i[1];
      pn.feedback_input_pair_a <= !i[1];
      pn.feedback_input_pair_b <= i[1];
      cyc(8);
      chk("ref", pll_ref_clk, i[0] ^ i[1]);
      chk("fb", pll_fb_clk, !(i[0] ^ i[1]));
    end
  endtask
  task automatic t_prof();
    for (int p = 0; p < 4; p++) begin
      apb(1, 12'h108 + 12'(p * 64), 32'h288 + 32'(p * 8));
      pn.profile_sel_bit0 <= p[0];
      pn.profile_sel_bit1 <= p[1];
      cyc(8);
      chk("prof", active_profile, p);
      chk("drv2", bank_drv_type[8:6], p + 1);
      chk("drv3", bank_drv_type[11:9], 0);
    end
    pn.profile_sel_bit0 <= 1'b0;
    pn.profile_sel_bit1 <= 1'b0;
    cyc(8);
  endtask
  task automatic t_oe();
    apb(1, 12'h10c, 32'h700);
    apb(1, 12'h110, 32'h0);
    for (int i = 0; i < 4; i++) begin
      pn.alt_enable_one <= i[0];
      pn.alt_enable_two <= i[1];
      cyc(48);
      chk("oe3", bank_oe_n[7:6], {!i[1], !i[0]});
      chk("oe4", bank_oe_n[9:8], 2'h3);
    end
  endtask
  task automatic t_gate();
    logic hi;
    hi = 1'b0;
    apb(1, 12'h104, 32'h2c0);
    cyc(40);
    repeat (32) begin
      @(posedge pclk);
      chk("held", bank_out[3:2], 0);
      hi = hi | bank_out[0];
    end
    chk("ungated", hi, 1);
    pn.sync_output_gate <= 1'b1;
    pulses(2, 8, 1);
  endtask
  task automatic t_byp();
    pulses(0, 8, 0);
    // bank 5 on divider 1 at ratio two runs at half bank 0's rate
    apb(1, 12'h004, 32'h2);
    apb(1, 12'h114, 32'h281);
    pulses(10, 16, 0);
    pn.loop_bypass_ctrl <= 1'b1;
    cyc(60);
    pulses(0, 20, 0);
    pn.loop_bypass_ctrl <= 1'b0;
    cyc(60);
  endtask
  task automatic t_tri();
    chk("locked", phase_acquired_n, 0);
    // status: locked, both selects left high by the routing scenario
    apb(0, `CFO_OFF_STATUS, 0);
    chk("status on", rd, 32'hc1);
    pn.global_tristate_ctrl <= 1'b1;
    cyc(8);
    chk("hiz", bank_oe_n, 20'hfffff);
    chk("fbbuf", fb_buf_en, 0);
    chk("unlock", phase_acquired_n, 1);
    apb(0, `CFO_OFF_STATUS, 0);
    chk("status tri", rd, 32'hd0);
    pn.global_tristate_ctrl <= 1'b0;
    cyc(60);
    chk("relock", phase_acquired_n, 0);
  endtask
  task automatic t_rst();
    pn.pll_reset_in <= 1'b1;
    cyc(8);
    chk("rst lock", phase_acquired_n, 1);
    chk("rst oe", bank_oe_n, 20'hfffff);
    repeat (40) begin
      @(posedge pclk);
      chk("rst out", bank_out, 0);
    end
    pn.pll_reset_in <= 1'b0;
    cyc(60);
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset for three cycles, then the scenarios in turn
  initial begin
    err_total = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pn = '0;
    cyc(3);
    presetn <= 1'b1;
    t_regs();
    t_route();
    t_prof();
    t_oe();
    t_gate();
    t_byp();
    t_tri();
    t_rst();
    print_verdict();
  end
  // watchdog, far beyond the two thousand cycles the run needs
  initial begin
    #250000;
    err_total++;
    print_verdict();
  end
endmodule // cfo_ctrl_tb
bind cfo_ctrl cfo_ctrl_properties chk_u (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .pins, .pll_ref_clk, .pll_fb_clk, .fb_buf_en,
  .phase_acquired_n, .active_profile, .bank_oe_n);
`default_nettype wire
